// File: src/bdm_data_memory.sv
`timescale 1ns/100ps

module bdm_data_memory
    import bdm_pkg::*;
(
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire logic                 wdt_idle_reset,
    // core access port
    input  wire logic                 core_rd,
    input  wire logic                 core_wr,
    input  wire logic                 core_bit_op,
    input  wire logic                 core_bit_set,
    input  wire logic [2:0]           core_bit_idx,
    input  wire logic [ADDR_W-1:0]    core_addr,
    input  wire logic [DATA_W-1:0]    core_wdata,
    output logic      [DATA_W-1:0]    core_rdata,
    output logic                      core_rvalid,
    // other special function registers
    output logic                      ext_rd,
    output logic                      ext_wr,
    output logic                      ext_bank,
    output logic      [ADDR_W-1:0]    ext_addr,
    output logic      [DATA_W-1:0]    ext_wdata,
    input  wire logic [DATA_W-1:0]    ext_rdata,
    input  wire logic                 ext_hit,
    input  wire logic                 ext_read_only,
    // status
    output logic                      bank_select_bit
);

    // general RAM has no reset; software initialises it before use
    // one flip-flop byte per location, picked by index
    logic [DATA_W-1:0] gpr_q [GPR_DEPTH];
    logic [DATA_W-1:0] pointer_bank0_q;
    logic [DATA_W-1:0] pointer_any_bank_q;
    logic              bank_q;

    // the two indirect ports are addresses, not storage
    function automatic logic is_port(input logic [7:0] a);
        is_port = (a == OFF_PORT_B0) || (a == OFF_PORT_ANY);
    endfunction : is_port

    function automatic logic is_gpr(input logic [7:0] a);
        is_gpr = (a >= GPR_START) && (a <= GPR_LAST);
    endfunction : is_gpr

    // pointers and bank select live here; every other special is outside
    function automatic logic is_local(input logic [7:0] a);
        is_local = (a >= OFF_PTR_B0) && (a <= OFF_BANK_SEL);
    endfunction : is_local

    // strobes leave the block only for specials held elsewhere
    function automatic logic goes_out(input bdm_target_t t, input logic local_hit);
        goes_out = (t == TGT_EXT) && !local_hit;
    endfunction : goes_out

    // unused bits of the bank register read as zero
    function automatic logic [7:0] bank_read(input logic b);
        bank_read = {7'h00, b};
    endfunction : bank_read

    // bank 1 answers only in the specials window and at eeprom control
    function automatic logic bank1_hit(input logic [7:0] a);
        bank1_hit = (a == OFF_EEPROM_CTRL) || (a <= SFR_LAST);
    endfunction : bank1_hit

    // effective address resolution
    logic                   acc_bank;
    logic [ADDR_W-1:0]      acc_addr;
    logic                   acc_void;
    logic                   acc_rd;
    logic                   acc_wr;
    logic [DATA_W-1:0]      acc_old;
    logic [DATA_W-1:0]      acc_wdata;
    logic [6:0]             gpr_idx;
    bdm_target_t            tgt;

    // a pointer aimed at a port would recurse, so that access is void
    always_comb begin
        acc_bank = 1'b0;
        acc_addr = core_addr;
        acc_void = 1'b0;
        case (core_addr)
            OFF_PORT_B0: begin
                acc_addr = pointer_bank0_q;
                acc_bank = 1'b0;
                acc_void = is_port(pointer_bank0_q);
            end
            OFF_PORT_ANY: begin
                acc_addr = pointer_any_bank_q;
                acc_bank = bank_q;
                acc_void = is_port(pointer_any_bank_q);
            end
            default: begin
                acc_void = 1'b0;
            end
        endcase
    end

    assign gpr_idx = 7'(acc_addr - GPR_START);

    // pick the storage group that answers this access
    always_comb begin
        if (acc_void) begin
            tgt = TGT_NONE;
        end else if (!acc_bank && is_gpr(acc_addr)) begin
            tgt = TGT_GPR;
        end else if (!acc_bank && acc_addr <= SFR_LAST) begin
            tgt = TGT_EXT;
        end else if (acc_bank && bank1_hit(acc_addr)) begin
            tgt = TGT_EXT;
        end else begin
            tgt = TGT_NONE;
        end
    end

    // local specials bypass the external path
    logic local_sfr;
    assign local_sfr = (tgt == TGT_EXT) && is_local(acc_addr);

    // old value feeds both reads and bit updates
    always_comb begin
        case (tgt)
            TGT_GPR: acc_old = gpr_q[gpr_idx];
            TGT_EXT: begin
                if (local_sfr) begin
                    case (acc_addr)
                        OFF_PTR_B0:   acc_old = pointer_bank0_q;
                        OFF_PTR_ANY:  acc_old = pointer_any_bank_q;
                        OFF_BANK_SEL: acc_old = bank_read(bank_q);
                        default:      acc_old = READ_ZERO;
                    endcase
                end else begin
                    acc_old = ext_hit ? ext_rdata : READ_ZERO;
                end
            end
            default: acc_old = READ_ZERO;
        endcase
    end

    // one-hot mask of the bit that a bit update touches
    logic [DATA_W-1:0] bit_mask;
    genvar bi;
    generate
        for (bi = 0; bi < DATA_W; bi++) begin : g_bit
            assign bit_mask[bi] = (core_bit_idx == 3'(bi));
        end
    endgenerate

    always_comb begin
        acc_wdata = core_wdata;
        if (core_bit_op) begin
            acc_wdata = core_bit_set ? (acc_old | bit_mask) : (acc_old & ~bit_mask);
        end
    end

    // a bit update is a write of the merged old value
    assign acc_rd = core_rd;
    assign acc_wr = core_wr || core_bit_op;

    // write qualifiers, one per storage group
    logic wr_gpr;
    logic wr_ptr_b0;
    logic wr_ptr_any;
    logic wr_bank;
    logic ext_sel;

    assign wr_gpr     = acc_wr && (tgt == TGT_GPR);
    assign wr_ptr_b0  = acc_wr && local_sfr && (acc_addr == OFF_PTR_B0);
    assign wr_ptr_any = acc_wr && local_sfr && (acc_addr == OFF_PTR_ANY);
    assign wr_bank    = acc_wr && local_sfr && (acc_addr == OFF_BANK_SEL);
    assign ext_sel    = goes_out(tgt, local_sfr);

    // general purpose RAM
    genvar gi;
    generate
        for (gi = 0; gi < GPR_DEPTH; gi++) begin : g_gpr
            always_ff @(posedge clk_sys) begin
                if (wr_gpr && gpr_idx == 7'(gi)) begin
                    gpr_q[gi] <= acc_wdata;
                end
            end
        end
    endgenerate

    // memory pointers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pointer_bank0_q <= 8'h00;
        end else if (wr_ptr_b0) begin
            pointer_bank0_q <= acc_wdata;
        end
    end

    // second pointer, paired with the any-bank port
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pointer_any_bank_q <= 8'h00;
        end else if (wr_ptr_any) begin
            pointer_any_bank_q <= acc_wdata;
        end
    end

    // bank select; a watchdog wake-up reset leaves it where software put it
    always_ff @(posedge clk_sys) begin
        if (rst && !wdt_idle_reset) begin
            bank_q <= BANK_SEL_RST[BANK_BIT];
        end else if (!rst && wr_bank) begin
            bank_q <= acc_wdata[BANK_BIT];
        end
    end

    // read answer valid one cycle after the request
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            core_rvalid <= 1'b0;
        end else begin
            core_rvalid <= acc_rd;
        end
    end

    // read data holds until the next read
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            core_rdata <= READ_ZERO;
        end else if (acc_rd) begin
            core_rdata <= acc_old;
        end
    end

    // read strobe toward the outside specials
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ext_rd <= 1'b0;
        end else begin
            ext_rd <= acc_rd && ext_sel;
        end
    end

    // write strobe, withheld for read-only specials
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ext_wr <= 1'b0;
        end else begin
            ext_wr <= acc_wr && ext_sel && !ext_read_only;
        end
    end

    // bank, address and data travel with the strobe as one cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ext_bank <= 1'b0;
        end else begin
            ext_bank <= acc_bank;
        end
    end

    // resolved address, after any pointer substitution
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ext_addr <= 8'h00;
        end else begin
            ext_addr <= acc_addr;
        end
    end

    // write data, already merged for bit updates
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ext_wdata <= 8'h00;
        end else begin
            ext_wdata <= acc_wdata;
        end
    end

    // registered copy of the bank bit for neighbouring blocks
    always_ff @(posedge clk_sys) begin
        if (rst && !wdt_idle_reset) begin
            bank_select_bit <= 1'b0;
        end else if (!rst) begin
            bank_select_bit <= bank_q;
        end
    end

endmodule : bdm_data_memory

// File: src/bdm_pkg.sv
package bdm_pkg;

    // data memory word
    localparam int unsigned DATA_W         = 8;
    localparam int unsigned ADDR_W         = 8;
    localparam int unsigned FULL_ADDR_W    = 9;

    // special function offsets owned by this block (bank 0)
    localparam logic [7:0] OFF_PORT_B0     = 8'h00;
    localparam logic [7:0] OFF_PTR_B0      = 8'h01;
    localparam logic [7:0] OFF_PORT_ANY    = 8'h02;
    localparam logic [7:0] OFF_PTR_ANY     = 8'h03;
    localparam logic [7:0] OFF_BANK_SEL    = 8'h04;

    // mapped area bounds
    localparam logic [7:0] SFR_START       = 8'h00;
    localparam logic [7:0] SFR_LAST        = 8'h3F;
    localparam logic [7:0] GPR_START       = 8'h40;
    localparam logic [7:0] GPR_LAST        = 8'hBF;
    localparam int unsigned GPR_DEPTH      = 128;

    // bank 1 location
    localparam logic [7:0] OFF_EEPROM_CTRL = 8'h40;

    // bank select field
    localparam int unsigned BANK_BIT       = 0;
    localparam logic [7:0] BANK_SEL_RST    = 8'h00;
    localparam logic [7:0] READ_ZERO       = 8'h00;

    typedef enum logic [2:0] {
        TGT_NONE = 3'b001,
        TGT_GPR  = 3'b010,
        TGT_EXT  = 3'b100
    } bdm_target_t;

endpackage : bdm_pkg

// File: dv/bdm_chk.sv
`timescale 1ns/100ps
module bdm_chk
    import bdm_pkg::*;
(
    // watched ports
    input wire logic       clk_sys, rst, wdt_idle_reset, core_rd, core_wr, core_bit_op,
    input wire logic       core_rvalid, ext_rd, ext_wr, ext_bank, ext_hit, ext_read_only, bank_select_bit,
    input wire logic [7:0] core_addr, core_wdata, core_rdata, ext_addr, ext_wdata, ext_rdata
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire logic sfr = core_addr >= 8'h05 && core_addr <= SFR_LAST;
    property p_rvalid; core_rd |=> core_rvalid; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    property p_bank_clr; disable iff (1'b0) rst && !wdt_idle_reset |=> !bank_select_bit; endproperty
    a_bank_clr: assert property (p_bank_clr) else $error("bank kept over reset");
    property p_direct_ext;
        core_wr && !core_bit_op && sfr && ext_hit && !ext_read_only
            |=> ext_wr && !ext_bank && ext_addr == $past(core_addr) && ext_wdata == $past(core_wdata);
    endproperty
    a_direct_ext: assert property (p_direct_ext) else $error("direct write misrouted");
    property p_ro; core_wr && ext_read_only |=> !ext_wr; endproperty
    a_ro: assert property (p_ro) else $error("read-only register written");
    property p_gpr; (core_wr || core_rd) && core_addr >= GPR_START |=> !ext_wr && !ext_rd; endproperty
    a_gpr: assert property (p_gpr) else $error("general ram access left the block");
    property p_unused; core_rd && sfr && !ext_hit |=> core_rdata == READ_ZERO; endproperty
    a_unused: assert property (p_unused) else $error("unused location not zero");
    property p_ext_rd; core_rd && sfr && ext_hit |=> core_rdata == $past(ext_rdata); endproperty
    a_ext_rd: assert property (p_ext_rd) else $error("special register data lost");
    property p_bank_wr;
        core_wr && !core_bit_op && core_addr == OFF_BANK_SEL |=> ##1 bank_select_bit == $past(core_wdata[0], 2);
    endproperty
    a_bank_wr: assert property (p_bank_wr) else $error("bank bit not taken");
endmodule : bdm_chk

bind bdm_data_memory bdm_chk chk_u (.*);

// File: dv/bdm_sfr_model.sv
`timescale 1ns/100ps
module bdm_sfr_model (
    // strobes from the block
    input wire logic       clk_sys, ext_wr, ext_bank,
    input wire logic [7:0] ext_addr, ext_wdata,
    // location the bench is resolving
    input wire logic [8:0] sel,
    // answer
    output logic [7:0]     ext_rdata,
    output logic           ext_hit, ext_read_only
);
    logic [7:0] mem [512];
    initial foreach (mem[i]) mem[i] = 8'h00;
    assign ext_hit = sel == 9'h140 || (!sel[8] && sel[7:0] inside {[8'h05:8'h0A], [8'h0F:8'h25], [8'h28:8'h3A]});
    assign ext_read_only = sel == 9'h008;
    // a non-zero pattern on misses so a zero read must come from the block
    assign ext_rdata = ext_hit ? mem[sel] : 8'h5A;
    always @(posedge clk_sys) if (ext_wr) mem[{ext_bank, ext_addr}] <= ext_wdata;
endmodule : bdm_sfr_model

// File: dv/tb.sv
`timescale 1ns/100ps
module tb;
    import bdm_pkg::*;
    logic clk_sys = 0, rst = 1, wdt_idle_reset = 0, core_rd = 0, core_wr = 0, core_bit_op = 0, core_bit_set = 0;
    logic core_rvalid, ext_rd, ext_wr, ext_bank, ext_hit, ext_read_only, bank_select_bit;
    logic [2:0] core_bit_idx = 0;
    logic [7:0] core_addr = 0, core_wdata = 0, core_rdata, ext_addr, ext_wdata, ext_rdata, got;
    logic [8:0] sel = 0;
    int errors = 0, samples_checked = 0;
    always #5 clk_sys = ~clk_sys;
    bdm_data_memory dut_u (.*);
    bdm_sfr_model far_u (.*);
    task automatic cmp(input string what, input logic [7:0] e, g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : cmp
    // o: 1 write, 2 read, 3 bit op (d[3] value, d[2:0] bit)
    task automatic acc(input int o, input logic [7:0] a, d, input logic [8:0] s = 9'h000);
        core_addr <= a;
        core_wdata <= d;
        sel <= s;
        core_wr <= o == 1;
        core_rd <= o == 2;
        core_bit_op <= o == 3;
        core_bit_set <= d[3];
        core_bit_idx <= d[2:0];
        @(posedge clk_sys);
        core_wr <= 1'b0;
        core_rd <= 1'b0;
        core_bit_op <= 1'b0;
        @(negedge clk_sys);
        got = core_rdata;
        if (o == 2) cmp("core_rvalid", 8'h01, {7'h00, core_rvalid});
        @(posedge clk_sys);
    endtask : acc
    task automatic rdc(input logic [7:0] a, e, input logic [8:0] s = 9'h000);
        acc(2, a, 8'h00, s);
        cmp("core_rdata", e, got);
    endtask : rdc
    task automatic report_and_stop();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    initial begin
        #20000;
        errors++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 0;
        rdc(OFF_BANK_SEL, 8'h00);
        acc(1, GPR_START, 8'h11);
        acc(1, GPR_LAST, 8'hEE);
        rdc(GPR_START, 8'h11);
        rdc(GPR_LAST, 8'hEE);
        acc(1, OFF_PTR_B0, 8'h41);
        rdc(OFF_PTR_B0, 8'h41);
        acc(1, OFF_PORT_B0, 8'h5A);
        rdc(8'h41, 8'h5A);
        acc(3, 8'h41, 8'h0F);
        acc(3, 8'h41, 8'h01);
        rdc(OFF_PORT_B0, 8'hD8);
        acc(1, OFF_BANK_SEL, 8'hFF);
        rdc(OFF_BANK_SEL, 8'h01);
        cmp("bank_select_bit", 8'h01, {7'h00, bank_select_bit});
        acc(1, OFF_PTR_ANY, OFF_EEPROM_CTRL);
        acc(1, OFF_PORT_ANY, 8'hA5, 9'h140);
        rdc(OFF_PORT_ANY, 8'hA5, 9'h140);
        rdc(GPR_START, 8'h11);
        acc(1, OFF_PTR_B0, GPR_START);
        rdc(OFF_PORT_B0, 8'h11);
        acc(1, 8'h07, 8'h3C, 9'h007);
        rdc(8'h07, 8'h3C, 9'h007);
        acc(1, OFF_PTR_ANY, 8'h41);
        acc(1, OFF_PORT_ANY, 8'h99);
        rdc(OFF_PORT_ANY, READ_ZERO);
        rdc(8'h41, 8'hD8);
        acc(1, OFF_PTR_ANY, OFF_PORT_ANY);
        acc(1, OFF_PORT_ANY, 8'h77);
        rdc(OFF_PORT_ANY, READ_ZERO);
        rdc(8'h0B, READ_ZERO, 9'h00B);
        acc(1, 8'h08, 8'h33, 9'h008);
        rdc(8'h08, 8'h00, 9'h008);
        rst <= 1;
        wdt_idle_reset <= 1;
        @(posedge clk_sys);
        rst <= 0;
        wdt_idle_reset <= 0;
        rdc(OFF_BANK_SEL, 8'h01);
        rst <= 1;
        @(posedge clk_sys);
        rst <= 0;
        rdc(OFF_BANK_SEL, 8'h00);
        report_and_stop();
    end
endmodule : tb
